// >>> core/tsc_pkg.sv
// constants and types for the per-thread schedule and cache-way registers
// assumes one core clock and a coprocessor move port from the pipeline
package tsc_pkg;

	localparam int TSC_NUM_TC  = 4;
	localparam int TSC_TC_W    = 2;
	localparam int TSC_MASK_W  = 8;
	localparam int TSC_WORD_W  = 32;

	// register numbers and selects on the coprocessor port
	localparam logic [4:0] TSC_REG_SCHED    = 5'h02;
	localparam logic [2:0] TSC_SEL_HINT     = 3'h6;
	localparam logic [2:0] TSC_SEL_FBACK    = 3'h7;
	localparam logic [4:0] TSC_REG_OPT      = 5'h03;
	localparam logic [2:0] TSC_SEL_OPT      = 3'h7;

	// options register field positions
	localparam int TSC_IWX_LSB = 8;
	localparam int TSC_DWX_LSB = 0;

	// reset values
	localparam logic [31:0] TSC_HINT_RST  = 32'h0000_0000;
	localparam logic [31:0] TSC_FBACK_RST = 32'h0000_0000;
	localparam logic [7:0]  TSC_MASK_RST  = 8'h00;

	// implemented ways of each primary cache, one bit per way
	localparam logic [7:0] TSC_IC_IMPL = 8'h0F;
	localparam logic [7:0] TSC_DC_IMPL = 8'h0F;

	// capability and policy straps
	localparam logic TSC_PART_CAPABLE   = 1'b1;
	localparam logic TSC_LOCK_IN_EXCL   = 1'b1;

	typedef logic [TSC_WORD_W-1:0] tsc_word_t;
	typedef logic [TSC_TC_W-1:0]   tsc_tc_t;
	typedef logic [TSC_MASK_W-1:0] tsc_mask_t;

endpackage

// >>> core/tsc_way_if.sv
// carrier between the register bank and one cache-way filter
// assumes the filter is purely combinational
`timescale 1ns/1ns
interface tsc_way_if;
	import tsc_pkg::*;

	tsc_mask_t [TSC_NUM_TC-1:0] excl;
	logic                       part_on;
	tsc_tc_t                    req_tc;
	tsc_mask_t                  impl;
	tsc_mask_t                  alloc_ok;
	tsc_mask_t                  hit_ok;
	tsc_mask_t                  lock_ok;

	modport regs (
		output excl,
		output part_on,
		output req_tc,
		output impl,
		input  alloc_ok,
		input  hit_ok,
		input  lock_ok
	);

	modport filt (
		input  excl,
		input  part_on,
		input  req_tc,
		input  impl,
		output alloc_ok,
		output hit_ok,
		output lock_ok
	);
endinterface

// >>> core/tsc_way_filter.sv
// per-cache way filter: which ways a thread may allocate, hit, lock
// assumes masks already hold zero for unimplemented ways
`timescale 1ns/1ns
module tsc_way_filter (
	tsc_way_if.filt wf
);
	import tsc_pkg::*;

	tsc_mask_t excl_sel;

	always_comb begin
		excl_sel = wf.part_on ? wf.excl[wf.req_tc] : TSC_MASK_RST;
		wf.alloc_ok = wf.impl & ~excl_sel;
		wf.hit_ok = wf.impl;
		if (TSC_LOCK_IN_EXCL) begin
			wf.lock_ok = wf.impl;
		end else begin
			wf.lock_ok = wf.impl & ~excl_sel;
		end
	end
endmodule

// >>> core/tsc_regs.sv
// per-thread schedule hint, schedule feedback and cache-way options bank
// assumes coprocessor moves arrive as one-cycle strobes on the core clock
`timescale 1ns/1ns

module tsc_regs (
	input  wire logic                                     mclk,
	input  wire logic                                     arst_n,
	input  wire logic                                     cop_rd,
	input  wire logic                                     cop_wr,
	input  wire tsc_pkg::tsc_tc_t                         cop_tc,
	input  wire logic [4:0]                               cop_reg,
	input  wire logic [2:0]                               cop_sel,
	input  wire tsc_pkg::tsc_word_t                       cop_wdata,
	output logic                                          cop_rack,
	output logic                                          cop_wack,
	output tsc_pkg::tsc_word_t                            cop_rdata,
	output logic                                          cop_hit,
	input  wire logic                                     part_enable,
	output logic                                          cache_partition_capable,
	output tsc_pkg::tsc_word_t [tsc_pkg::TSC_NUM_TC-1:0]  thread_schedule_hint,
	input  wire logic [tsc_pkg::TSC_NUM_TC-1:0]           fb_load,
	input  wire tsc_pkg::tsc_word_t [tsc_pkg::TSC_NUM_TC-1:0] fb_value,
	input  wire tsc_pkg::tsc_tc_t                         ic_req_tc,
	output tsc_pkg::tsc_mask_t                            ic_alloc_ways,
	output tsc_pkg::tsc_mask_t                            ic_hit_ways,
	output tsc_pkg::tsc_mask_t                            ic_lock_ways,
	input  wire tsc_pkg::tsc_tc_t                         dc_req_tc,
	output tsc_pkg::tsc_mask_t                            dc_alloc_ways,
	output tsc_pkg::tsc_mask_t                            dc_hit_ways,
	output tsc_pkg::tsc_mask_t                            dc_lock_ways
);
	import tsc_pkg::*;

	typedef struct packed {
		tsc_word_t [TSC_NUM_TC-1:0] hint;
		tsc_word_t [TSC_NUM_TC-1:0] fback;
		tsc_mask_t [TSC_NUM_TC-1:0] iwx;
		tsc_mask_t [TSC_NUM_TC-1:0] dwx;
		tsc_word_t                  rdata;
		logic                       rack;
		logic                       wack;
		logic                       hit;
	} tsc_state_t;

	localparam tsc_state_t TSC_STATE_RST = '{
		hint:  {TSC_NUM_TC{TSC_HINT_RST}},
		fback: {TSC_NUM_TC{TSC_FBACK_RST}},
		iwx:   {TSC_NUM_TC{TSC_MASK_RST}},
		dwx:   {TSC_NUM_TC{TSC_MASK_RST}},
		rdata: 32'h0000_0000,
		rack:  1'b0,
		wack:  1'b0,
		hit:   1'b0
	};

	// masks only exist when the core can partition its caches
	localparam tsc_mask_t TSC_IC_WR = TSC_PART_CAPABLE ? TSC_IC_IMPL : 8'h00;
	localparam tsc_mask_t TSC_DC_WR = TSC_PART_CAPABLE ? TSC_DC_IMPL : 8'h00;

	tsc_state_t s_q;
	tsc_state_t s_d;
	logic       sel_hint;
	logic       sel_fback;
	logic       sel_opt;
	logic       part_on;

	tsc_way_if ic_wf ();
	tsc_way_if dc_wf ();

	// register select decode
	always_comb begin
		sel_hint = 1'b0;
		sel_fback = 1'b0;
		sel_opt = 1'b0;
		if (cop_reg == TSC_REG_SCHED && cop_sel == TSC_SEL_HINT) begin
			sel_hint = 1'b1;
		end else if (cop_reg == TSC_REG_SCHED && cop_sel == TSC_SEL_FBACK) begin
			sel_fback = 1'b1;
		end else if (cop_reg == TSC_REG_OPT && cop_sel == TSC_SEL_OPT) begin
			sel_opt = 1'b1;
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rack = cop_rd;
		s_d.wack = cop_wr & ~cop_rd;
		s_d.hit = (cop_rd | cop_wr) & (sel_hint | sel_fback | sel_opt);
		if (cop_rd) begin
			s_d.rdata = 32'h0000_0000;
		end
		// software writes; a read in the same cycle takes precedence
		if (cop_wr && !cop_rd) begin
			if (sel_hint) begin
				s_d.hint[cop_tc] = cop_wdata;
			end else if (sel_fback) begin
				s_d.fback[cop_tc] = cop_wdata;
			end else if (sel_opt) begin
				s_d.iwx[cop_tc] = cop_wdata[TSC_IWX_LSB +: TSC_MASK_W] & TSC_IC_WR;
				s_d.dwx[cop_tc] = cop_wdata[TSC_DWX_LSB +: TSC_MASK_W] & TSC_DC_WR;
			end
		end
		// scheduler update beats a software write in the same cycle
		for (int t = 0; t < TSC_NUM_TC; t++) begin
			if (fb_load[t]) begin
				s_d.fback[t] = fb_value[t];
			end
		end
		if (cop_rd) begin
			if (sel_hint) begin
				s_d.rdata = s_q.hint[cop_tc];
			end else if (sel_fback) begin
				s_d.rdata = s_q.fback[cop_tc];
			end else if (sel_opt) begin
				s_d.rdata = {16'h0000, s_q.iwx[cop_tc], s_q.dwx[cop_tc]};
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= TSC_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// exclusion only when both supported and switched on
	assign part_on = TSC_PART_CAPABLE & part_enable;

	assign cop_rack = s_q.rack;
	assign cop_wack = s_q.wack;
	assign cop_rdata = s_q.rdata;
	assign cop_hit = s_q.hit;
	assign cache_partition_capable = TSC_PART_CAPABLE;

	// hint handed unchanged to the scheduler, which applies it inside the vpe share
	genvar g;
	generate
		for (g = 0; g < TSC_NUM_TC; g++) begin : g_tc
			assign thread_schedule_hint[g] = s_q.hint[g];
			assign ic_wf.excl[g] = s_q.iwx[g];
			assign dc_wf.excl[g] = s_q.dwx[g];
		end
	endgenerate

	assign ic_wf.part_on = part_on;
	assign ic_wf.req_tc = ic_req_tc;
	assign ic_wf.impl = TSC_IC_IMPL;
	assign dc_wf.part_on = part_on;
	assign dc_wf.req_tc = dc_req_tc;
	assign dc_wf.impl = TSC_DC_IMPL;

	tsc_way_filter u_ic_filter (
		.wf (ic_wf.filt)
	);

	tsc_way_filter u_dc_filter (
		.wf (dc_wf.filt)
	);

	assign ic_alloc_ways = ic_wf.alloc_ok;
	assign ic_hit_ways = ic_wf.hit_ok;
	assign ic_lock_ways = ic_wf.lock_ok;
	assign dc_alloc_ways = dc_wf.alloc_ok;
	assign dc_hit_ways = dc_wf.hit_ok;
	assign dc_lock_ways = dc_wf.lock_ok;

endmodule

// >>> verif/tsc_regs_chk.sv
// port assertions for the cache-way register bank
// assumes one core clock and an async active-low reset
`timescale 1ns/1ns
module tsc_regs_chk (
	input logic               mclk,
	input logic               arst_n,
	input logic               cop_rd,
	input logic               cop_wr,
	input logic [4:0]         cop_reg,
	input logic               cop_rack,
	input logic               cop_wack,
	input tsc_pkg::tsc_word_t cop_rdata,
	input logic               part_enable,
	input logic               cache_partition_capable,
	input tsc_pkg::tsc_mask_t ic_alloc_ways,
	input tsc_pkg::tsc_mask_t ic_hit_ways,
	input tsc_pkg::tsc_mask_t dc_lock_ways
);
	import tsc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_rack; cop_rd |=> cop_rack; endproperty
	a_rack: assert property (p_rack) else $error("read answer late");
	property p_wack; cop_wr && !cop_rd |=> cop_wack; endproperty
	a_wack: assert property (p_wack) else $error("write answer late");
	property p_rsv; cop_rack && $past(cop_reg) == TSC_REG_OPT |-> cop_rdata[31:16] == 16'h0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_imp; cop_rack && $past(cop_reg) == TSC_REG_OPT
		|-> (cop_rdata[15:0] & ~{TSC_IC_IMPL, TSC_DC_IMPL}) == 16'h0000; endproperty
	a_imp: assert property (p_imp) else $error("absent way bit set");
	property p_cap; cache_partition_capable == TSC_PART_CAPABLE; endproperty
	a_cap: assert property (p_cap) else $error("capability wrong");
	property p_off; !part_enable |-> ic_alloc_ways == TSC_IC_IMPL; endproperty
	a_off: assert property (p_off) else $error("masks used while off");
	property p_hit; ic_hit_ways == TSC_IC_IMPL; endproperty
	a_hit: assert property (p_hit) else $error("hit ways wrong");
	property p_lock; dc_lock_ways == TSC_DC_IMPL; endproperty
	a_lock: assert property (p_lock) else $error("lock ways wrong");
endmodule
bind tsc_regs tsc_regs_chk u_chk (.mclk, .arst_n, .cop_rd, .cop_wr, .cop_reg, .cop_rack, .cop_wack, .cop_rdata,
	.part_enable, .cache_partition_capable, .ic_alloc_ways, .ic_hit_ways, .dc_lock_ways);

// >>> verif/tsc_sched_model.sv
// scheduler and cache-request stand-in
// assumes callers enter its tasks just after a falling edge
`timescale 1ns/1ns
module tsc_sched_model (
	input  logic                                         mclk,
	output logic [tsc_pkg::TSC_NUM_TC-1:0]               fb_load,
	output tsc_pkg::tsc_word_t [tsc_pkg::TSC_NUM_TC-1:0] fb_value,
	output tsc_pkg::tsc_tc_t                             ic_req_tc,
	output tsc_pkg::tsc_tc_t                             dc_req_tc
);
	import tsc_pkg::*;
	initial begin
		fb_load = '0;
		fb_value = '0;
		ic_req_tc = '0;
		dc_req_tc = '0;
	end
	task automatic load(input int t, input tsc_word_t v);
		@(negedge mclk);
		fb_load[t] = 1'b1;
		fb_value[t] = v;
		@(negedge mclk);
		fb_load[t] = 1'b0;
		fb_value[t] = ~v;
	endtask
	task automatic req(input int t);
		ic_req_tc = tsc_tc_t'(t);
		dc_req_tc = tsc_tc_t'(t);
	endtask
endmodule

// >>> verif/tsc_regs_tb.sv
// bench for the schedule and cache-way register bank
// assumes the model drives feedback loads and cache requests
`timescale 1ns/1ns
module tsc_regs_tb;
	import tsc_pkg::*;
	localparam logic [7:0] a_hint = {TSC_REG_SCHED, TSC_SEL_HINT};
	localparam logic [7:0] a_fb = {TSC_REG_SCHED, TSC_SEL_FBACK};
	localparam logic [7:0] a_opt = {TSC_REG_OPT, TSC_SEL_OPT};
	logic      mclk = 1'b0, arst_n = 1'b0, cop_rd = 1'b0, cop_wr = 1'b0, part_enable = 1'b0;
	logic      cop_rack, cop_wack, cop_hit, cache_partition_capable;
	tsc_tc_t   cop_tc = '0, ic_req_tc, dc_req_tc;
	logic      [4:0] cop_reg = '0;
	logic      [2:0] cop_sel = '0;
	tsc_word_t cop_wdata = '0, cop_rdata;
	tsc_word_t [TSC_NUM_TC-1:0] thread_schedule_hint, fb_value;
	logic      [TSC_NUM_TC-1:0] fb_load;
	tsc_mask_t ic_alloc_ways, ic_hit_ways, ic_lock_ways, dc_alloc_ways, dc_hit_ways, dc_lock_ways;
	int        fail_count = 0, num_checks = 0;
	tsc_regs uut (.mclk, .arst_n, .cop_rd, .cop_wr, .cop_tc, .cop_reg, .cop_sel, .cop_wdata, .cop_rack, .cop_wack,
		.cop_rdata, .cop_hit, .part_enable, .cache_partition_capable, .thread_schedule_hint, .fb_load, .fb_value,
		.ic_req_tc, .ic_alloc_ways, .ic_hit_ways, .ic_lock_ways, .dc_req_tc, .dc_alloc_ways, .dc_hit_ways,
		.dc_lock_ways);
	tsc_sched_model sched (.mclk, .fb_load, .fb_value, .ic_req_tc, .dc_req_tc);
	always #10 mclk = ~mclk;
	task automatic chk(input tsc_word_t got, input tsc_word_t exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cop(input logic r, w, h, input int t, input logic [7:0] a, input tsc_word_t d, e);
		@(negedge mclk);
		{cop_rd, cop_wr, cop_tc, cop_reg, cop_sel, cop_wdata} = {r, w, tsc_tc_t'(t), a, d};
		@(negedge mclk);
		{cop_rd, cop_wr} = 2'b00;
		chk(32'({cop_rack, cop_wack, cop_hit}), 32'({r, w & ~r, h}));
		if (r)
			chk(cop_rdata, e);
	endtask
	task automatic t_reset;
		for (int t = 0; t < TSC_NUM_TC; t++) begin
			cop(1, 0, 1, t, a_hint, '0, TSC_HINT_RST);
			cop(1, 0, 1, t, a_fb, '0, TSC_FBACK_RST);
			cop(1, 0, 1, t, a_opt, '0, '0);
		end
		$display("t_reset end");
	endtask
	task automatic t_hint;
		for (int t = 0; t < TSC_NUM_TC; t++)
			cop(0, 1, 1, t, a_hint, 32'hA5C3_0000 + t, '0);
		for (int t = 0; t < TSC_NUM_TC; t++) begin
			cop(1, 0, 1, t, a_hint, '0, 32'hA5C3_0000 + t);
			chk(thread_schedule_hint[t], 32'hA5C3_0000 + t);
		end
		$display("t_hint end");
	endtask
	task automatic t_opt;
		tsc_mask_t mi, md;
		for (int t = 0; t < TSC_NUM_TC; t++) begin
			cop(0, 1, 1, t, a_opt, 32'hFFFF_F0F0 | t << 8 | 1 << t, '0);
			cop(1, 0, 1, t, a_opt, '0, t << 8 | 1 << t);
		end
		for (int p = 1; p >= 0; p--)
			for (int t = 0; t < TSC_NUM_TC; t++) begin
				@(negedge mclk);
				part_enable = p[0];
				sched.req(t);
				mi = p ? ~tsc_mask_t'(t) : 8'hFF;
				md = p ? ~tsc_mask_t'(1 << t) : 8'hFF;
				#1;
				chk({ic_alloc_ways, dc_alloc_ways, ic_hit_ways, dc_hit_ways},
					{TSC_IC_IMPL & mi, TSC_DC_IMPL & md, TSC_IC_IMPL, TSC_DC_IMPL});
				chk({16'h0, ic_lock_ways, dc_lock_ways}, {16'h0, TSC_IC_IMPL, TSC_DC_IMPL});
			end
		$display("t_opt end");
	endtask
	task automatic t_fb;
		sched.load(2, 32'h1234_5678);
		cop(1, 0, 1, 2, a_fb, '0, 32'h1234_5678);
		cop(0, 1, 1, 1, a_fb, 32'h5A5A_0001, '0);
		cop(1, 0, 1, 1, a_fb, '0, 32'h5A5A_0001);
		fork
			sched.load(3, 32'hCAFE_0003);
			cop(0, 1, 1, 3, a_fb, 32'h0000_BEEF, '0);
		join
		cop(1, 0, 1, 3, a_fb, '0, 32'hCAFE_0003);
		$display("t_fb end");
	endtask
	task automatic t_refuse;
		cop(1, 0, 0, 0, 8'hF8, '0, '0);
		cop(0, 1, 0, 0, {TSC_REG_OPT, TSC_SEL_HINT}, 32'h0000_0F0F, '0);
		cop(1, 0, 1, 0, a_opt, '0, 32'h0000_0001);
		cop(1, 1, 1, 0, a_hint, 32'hDEAD_BEEF, 32'hA5C3_0000);
		cop(1, 0, 1, 0, a_hint, '0, 32'hA5C3_0000);
		$display("t_refuse end");
	endtask
	task automatic t_rst_mid;
		@(negedge mclk);
		arst_n = 1'b0;
		repeat (2) @(negedge mclk);
		chk(32'({cop_rack, cop_wack, cop_hit}), 32'h0000_0000);
		chk(cop_rdata, TSC_HINT_RST);
		arst_n = 1'b1;
		t_reset();
		$display("t_rst_mid end");
	endtask
	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge mclk);
		arst_n = 1'b1;
		t_reset();
		t_hint();
		t_opt();
		t_fb();
		t_refuse();
		t_rst_mid();
		complete_run();
	end
endmodule
